// ===== tb/analog_model.sv
`timescale 1ns/1ps
// --------
// Comparator and soft-start node model
// --------
module analog_model
    import buck_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire gate_drive_t gate,
    input wire analog_flags_t inj,
    input wire logic slow,
    output analog_flags_t flags
);
    logic [3:0] on_q;
    logic [4:0] dis_q;

    // Inductor ramp: peak trips a few cycles into conduction
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            on_q <= 4'h0;
        else if (!gate.high_side_on)
            on_q <= 4'h0;
        else if (on_q != 4'hf)
            on_q <= on_q + 4'h1;
    end

    // Node empties only while pulled down; slow mode mimics a big cap
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            dis_q <= 5'h00;
        else if (!gate.soft_start_discharge)
            dis_q <= 5'h00;
        else if (dis_q != 5'h1f)
            dis_q <= dis_q + 5'h01;
    end

    // Injected faults ride on top of the modelled peak comparator; the node-low flag comes from the model alone
    always_comb
    begin
        flags = inj;
        flags.peak_current_trip = inj.peak_current_trip | (on_q >= 4'h3);
        flags.soft_start_track_node_low = (dis_q >= (slow ? 5'h14 : 5'h03));
    end
endmodule : analog_model

// ===== tb/buck_sva.sv
`timescale 1ns/1ps
// --------
// Gate and protection checker
// --------
module buck_sva
    import buck_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire analog_flags_t flags_async,
    input wire gate_drive_t gate
);
    logic [1:0] up_q;
    logic ok;

    // Warm-up, so no past value reaches back into reset
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            up_q <= 2'h0;
        else if (up_q != 2'h3)
            up_q <= up_q + 2'h1;
    end
    assign ok = (up_q == 2'h3);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Flags reach the gates two flops late; the peak cut is one flop later still
    no_overlap_a: assert property (!(gate.high_side_on && gate.low_side_on))
        else $error("high and low drives overlap");
    sink_cut_a: assert property (ok && $past(flags_async.sink_limit, 2) |-> !gate.low_side_on)
        else $error("low side kept on at sink limit");
    ovp_block_a: assert property (ok && $past(flags_async.output_overvoltage_guard, 2)
        |-> !gate.high_side_on)
        else $error("high side on during overvoltage");
    peak_off_a: assert property (ok && $past(flags_async.peak_current_trip, 3)
        |-> !gate.high_side_on)
        else $error("high side on after peak trip");
    temp_stop_a: assert property (flags_async.over_temp [*4]
        |-> !gate.high_side_on && !gate.low_side_on)
        else $error("switching while hot");
    discharge_idle_a: assert property (gate.soft_start_discharge
        |-> !gate.high_side_on && !gate.low_side_on)
        else $error("switching during discharge");
    restart_wait_a: assert property (ok && gate.soft_start_discharge
        && !flags_async.soft_start_track_node_low
        && !$past(flags_async.soft_start_track_node_low)
        && !$past(flags_async.soft_start_track_node_low, 2)
        && !flags_async.over_temp && !$past(flags_async.over_temp)
        && !$past(flags_async.over_temp, 2)
        |=> gate.soft_start_discharge)
        else $error("discharge left before node low");
    hold_low_a: assert property ((flags_async.source_limit && gate.low_side_on) [*3]
        |=> !gate.high_side_on)
        else $error("high side on over source limit");
endmodule : buck_sva

bind buck_switch_protection_fsm buck_sva u_sva (
    .clk(clk),
    .rst(rst),
    .flags_async(flags_async),
    .gate(gate)
);

// ===== tb/buck_switch_protection_fsm_tb.sv
`timescale 1ns/1ps
// --------
// Bench for the switch and protection sequencer
// --------
module buck_switch_protection_fsm_tb
    import buck_pkg::*;
;
    localparam int OL = 4;
    localparam int HW = 8;
    localparam int DIV = 12;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic slow = 1'b1;
    logic last_err;
    logic [31:0] rd;
    analog_flags_t inj = '0;
    analog_flags_t flags;
    gate_drive_t gate;
    logic irq;
    int bad_count = 0;
    int num_checks = 0;
    int n;

    // Clock
    initial
    begin
        forever #5 clk = ~clk;
    end

    // Short counts keep the hiccup runs brief
    buck_switch_protection_fsm #(.OVERLOAD_LIMIT(OL), .HICCUP_WAIT(HW)) DUT (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .flags_async(flags), .gate(gate), .irq(irq));
    analog_model partner (.clk(clk), .rst(rst), .gate(gate), .inj(inj), .slow(slow),
        .flags(flags));

    // --------
    // Shared tasks
    // --------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run;
        if (bad_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run

    task automatic give_up;
        bad_count++;
        $display("wrong value at %0t: wait ran out", $time);
        complete_run();
    endtask : give_up

    // Idle edge first, so back-to-back calls never reassign in one step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1)
            give_up();
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_gate(input gate_drive_t want, input int lim);
        int k;
        k = 0;
        while (gate !== want)
        begin
            @(posedge clk);
            k++;
            if (k > lim)
                give_up();
        end
    endtask : wait_gate

    // Counts cycles until the state field matches, or stops matching
    task automatic poll(input logic [2:0] st, input logic eq);
        n = 0;
        do
        begin
            apb(1'b0, STATUS_OFFSET, 32'h0);
            n += 3;
            if (n > 3000)
                give_up();
        end
        while ((rd[6:4] === st) != eq);
    endtask : poll

    // First cycle skipped: a tick may land before the flag is synced
    task automatic high_stays_off;
        repeat (DIV) @(posedge clk);
        repeat (2 * DIV)
        begin
            @(posedge clk);
            check(gate.high_side_on, 1'b0);
        end
    endtask : high_stays_off

    // --------
    // Scenarios
    // --------
    task automatic t_start;
        repeat (12)
        begin
            @(posedge clk);
            check(gate, 3'b001);
        end
        slow <= 1'b0;
        wait_gate(3'b100, 200);
    endtask : t_start

    task automatic t_regs;
        apb(1'b0, CTRL_OFFSET, 32'h0);
        check(rd, CTRL_RESET);
        apb(1'b0, IRQ_ENABLE_OFFSET, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        check({rd[30:0], last_err}, 32'h1);
        apb(1'b1, OL_COUNT_OFFSET, 32'h5);
        apb(1'b0, HICCUP_COUNT_OFFSET, 32'h0);
        check(rd, 32'h0);
        apb(1'b1, CTRL_OFFSET, 32'h0000_0c00);
        repeat (DIV) @(posedge clk);
        check(gate, 3'b000);
        apb(1'b1, CTRL_OFFSET, 32'h0000_0c01);
        apb(1'b0, CTRL_OFFSET, 32'h0);
        check(rd, 32'h0000_0c01);
    endtask : t_regs

    task automatic t_peak;
        wait_gate(3'b010, 400);
        wait_gate(3'b100, 400);
        inj.peak_current_trip <= 1'b1;
        repeat (4) @(posedge clk);
        check(gate, 3'b010);
        inj.peak_current_trip <= 1'b0;
    endtask : t_peak

    task automatic t_limits;
        wait_gate(3'b010, 400);
        inj.source_limit <= 1'b1;
        high_stays_off();
        inj.source_limit <= 1'b0;
        wait_gate(3'b100, DIV + 6);
        inj.output_overvoltage_guard <= 1'b1;
        high_stays_off();
        inj.output_overvoltage_guard <= 1'b0;
        wait_gate(3'b100, DIV + 6);
        apb(1'b0, IRQ_STATUS_OFFSET, 32'h0);
        check(rd, 32'h10);
    endtask : t_limits

    task automatic t_sink;
        apb(1'b1, IRQ_ENABLE_OFFSET, 32'h8);
        // Start of the low phase, so no tick lands before the check
        wait_gate(3'b100, 400);
        wait_gate(3'b010, 400);
        inj.sink_limit <= 1'b1;
        repeat (4) @(posedge clk);
        check(gate, 3'b000);
        inj.sink_limit <= 1'b0;
        check(irq, 1'b1);
        apb(1'b1, IRQ_ENABLE_OFFSET, 32'h0);
        @(posedge clk);
        check(irq, 1'b0);
        apb(1'b1, IRQ_ENABLE_OFFSET, 32'h8);
        @(posedge clk);
        check(irq, 1'b1);
        apb(1'b1, IRQ_CLEAR_OFFSET, 32'h8);
        @(posedge clk);
        check(irq, 1'b0);
    endtask : t_sink

    task automatic t_overload;
        apb(1'b1, IRQ_ENABLE_OFFSET, 32'h5);
        repeat (2)
        begin
            inj.overload <= 1'b1;
            repeat (2 * DIV) @(posedge clk);
            inj.overload <= 1'b0;
            repeat (DIV) @(posedge clk);
        end
        poll(3'h1, 1'b1);
        check(n, 3);
        inj.overload <= 1'b1;
        poll(3'h2, 1'b1);
        check(n >= (OL - 1) * DIV && n <= (OL + 2) * DIV + 6, 1'b1);
        check({irq, gate[2:1]}, 3'b100);
        inj.overload <= 1'b0;
        poll(3'h2, 1'b0);
        check(n >= (HW - 1) * DIV - 6 && n <= (HW + 1) * DIV + 6, 1'b1);
        wait_gate(3'b100, 400);
        apb(1'b0, IRQ_STATUS_OFFSET, 32'h0);
        check(rd, 32'h15);
    endtask : t_overload

    task automatic t_thermal;
        apb(1'b1, IRQ_ENABLE_OFFSET, 32'h2);
        inj.over_temp <= 1'b1;
        repeat (4) @(posedge clk);
        check({irq, gate[2:1]}, 3'b100);
        repeat (2 * HW * DIV) @(posedge clk);
        poll(3'h3, 1'b1);
        check(n, 3);
        inj.over_temp <= 1'b0;
        inj.cool_below <= 1'b1;
        poll(3'h4, 1'b1);
        poll(3'h4, 1'b0);
        check(n >= (HW - 1) * DIV - 6 && n <= (HW + 1) * DIV + 6, 1'b1);
        inj.cool_below <= 1'b0;
        wait_gate(3'b100, 400);
    endtask : t_thermal

    task automatic t_reset;
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        check({irq, gate}, 4'h1);
        rst <= 1'b0;
        apb(1'b0, OL_COUNT_OFFSET, 32'h0);
        check(rd, 32'h0);
        wait_gate(3'b100, 400);
    endtask : t_reset

    // Main sequence
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_start();
        t_regs();
        t_peak();
        t_limits();
        t_sink();
        t_overload();
        t_thermal();
        t_reset();
        complete_run();
    end
endmodule : buck_switch_protection_fsm_tb

// ===== verilog/buck_pkg.sv
package buck_pkg;

    // ------------------------------------------------------------------
    // Register map (APB byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h08;
    localparam logic [7:0] IRQ_ENABLE_OFFSET = 8'h0c;
    localparam logic [7:0] IRQ_CLEAR_OFFSET = 8'h10;
    localparam logic [7:0] OL_COUNT_OFFSET = 8'h14;
    localparam logic [7:0] HICCUP_COUNT_OFFSET = 8'h18;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_CYCLE_DIV_LSB = 8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0a01;
    localparam int IRQ_WIDTH = 5;
    localparam int IRQ_OL_SHUTDOWN_BIT = 0;
    localparam int IRQ_THERMAL_SHUTDOWN_BIT = 1;
    localparam int IRQ_RESTART_BIT = 2;
    localparam int IRQ_SINK_LIMIT_BIT = 3;
    localparam int IRQ_OVERVOLTAGE_BIT = 4;
    localparam logic [IRQ_WIDTH-1:0] IRQ_ENABLE_RESET = 5'h00;

    // ------------------------------------------------------------------
    // Timing counts, in switching cycles; the divider default is in clocks per cycle
    // ------------------------------------------------------------------
    localparam int OVERLOAD_LIMIT_CYCLES = 512;
    localparam int HICCUP_WAIT_CYCLES = 16384;
    localparam int CYCLE_DIV_DEFAULT = 10;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_DISCHARGE,
        ST_RUN,
        ST_OL_HICCUP,
        ST_THERMAL_WAIT,
        ST_THERMAL_HICCUP
    } seq_state_t;

    // Comparator flags from the analog side
    typedef struct packed {
        logic peak_current_trip;
        logic source_limit;
        logic sink_limit;
        logic overload;
        logic over_temp;
        logic cool_below;
        logic output_overvoltage_guard;
        logic soft_start_track_node_low;
    } analog_flags_t;

    // Gate drive and soft-start control
    typedef struct packed {
        logic high_side_on;
        logic low_side_on;
        logic soft_start_discharge;
    } gate_drive_t;

endpackage : buck_pkg

// ===== verilog/buck_switch_protection_fsm.sv
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
// How it works
// - Peak current trip: high off, low on.
// - Cycle-end source limit keeps low on.
// - High side restarts only below source limit.
// - Sink limit: both off until next cycle.
// - Overload beyond 512 cycles shuts switching down.
// - Overload hiccup waits 16384 cycles, then restarts.
// - Over-temperature stops all switching.
// - Thermal hiccup count starts after cooling.
// - Thermal hiccup expiry restarts power-up sequence.
// - Overvoltage keeps high side off until cleared.
// - Restart waits for soft-start node discharge.
module buck_switch_protection_fsm
    import buck_pkg::*;
#(
    parameter int OVERLOAD_LIMIT = OVERLOAD_LIMIT_CYCLES,
    parameter int HICCUP_WAIT = HICCUP_WAIT_CYCLES
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire analog_flags_t flags_async,
    output gate_drive_t gate,
    output logic irq
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    localparam int CNT_W = 16;
    localparam logic [CNT_W-1:0] OL_LIMIT = CNT_W'(OVERLOAD_LIMIT);
    localparam logic [CNT_W-1:0] HICCUP_LIMIT = CNT_W'(HICCUP_WAIT);

    analog_flags_t flags;
    logic tick;
    logic [31:0] ctrl_q;
    logic [IRQ_WIDTH-1:0] irq_status_q;
    logic [IRQ_WIDTH-1:0] irq_enable_q;
    logic [IRQ_WIDTH-1:0] irq_events;
    seq_state_t state_q;
    logic [CNT_W-1:0] ol_count_q;
    logic [CNT_W-1:0] hiccup_count_q;
    logic high_on_q;
    logic low_on_q;
    logic sink_block_q;
    logic source_hold_q;
    logic ovp_block_q;
    logic switching;
    logic apb_write;
    logic apb_read;
    logic ol_trip;
    logic hiccup_done;

    // ------------------------------------------------------------------
    // Flag synchroniser and switching-cycle divider
    // ------------------------------------------------------------------
    flag_sync #(.WIDTH($bits(analog_flags_t))) u_sync (
        .clk(clk),
        .rst(rst),
        .async_in(flags_async),
        .sync_out(flags)
    );

    cycle_tick_gen #(.DIV_WIDTH(16)) u_tick (
        .clk(clk),
        .rst(rst),
        .div_value(ctrl_q[CTRL_CYCLE_DIV_LSB +: 16]),
        .tick(tick)
    );

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    // Zero wait states keeps the slave trivially simple
    assign pready = 1'b1;
    assign apb_write = psel && penable && pwrite;
    assign apb_read = psel && !pwrite;

    function automatic logic addr_known(input logic [7:0] a);
        addr_known = (a == CTRL_OFFSET) || (a == STATUS_OFFSET) ||
            (a == IRQ_STATUS_OFFSET) || (a == IRQ_ENABLE_OFFSET) ||
            (a == IRQ_CLEAR_OFFSET) || (a == OL_COUNT_OFFSET) ||
            (a == HICCUP_COUNT_OFFSET);
    endfunction : addr_known

    assign pslverr = psel && penable && !addr_known(paddr);

    // Control and enable registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_q <= CTRL_RESET;
            irq_enable_q <= IRQ_ENABLE_RESET;
        end
        else if (apb_write && paddr == CTRL_OFFSET)
        begin
            ctrl_q <= pwdata;
        end
        else if (apb_write && paddr == IRQ_ENABLE_OFFSET)
        begin
            irq_enable_q <= pwdata[IRQ_WIDTH-1:0];
        end
    end

    // Read mux, registered so data comes from flip-flops
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            prdata <= '0;
        end
        else if (apb_read && !penable)
        begin
            case (paddr)
                CTRL_OFFSET: prdata <= ctrl_q;
                STATUS_OFFSET: prdata <= {24'h000000, 1'b0, 3'(state_q),
                    sink_block_q, source_hold_q, low_on_q, high_on_q};
                IRQ_STATUS_OFFSET: prdata <= {27'h0000000, irq_status_q};
                IRQ_ENABLE_OFFSET: prdata <= {27'h0000000, irq_enable_q};
                OL_COUNT_OFFSET: prdata <= {16'h0000, ol_count_q};
                HICCUP_COUNT_OFFSET: prdata <= {16'h0000, hiccup_count_q};
                default: prdata <= '0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    assign ol_trip = tick && state_q == ST_RUN && flags.overload && ol_count_q >= OL_LIMIT;
    assign hiccup_done = tick && hiccup_count_q >= HICCUP_LIMIT - CNT_W'(1);

    always_comb
    begin
        irq_events = '0;
        irq_events[IRQ_OL_SHUTDOWN_BIT] = ol_trip;
        irq_events[IRQ_THERMAL_SHUTDOWN_BIT] = flags.over_temp && state_q != ST_THERMAL_WAIT
            && state_q != ST_THERMAL_HICCUP;
        irq_events[IRQ_RESTART_BIT] = hiccup_done &&
            (state_q == ST_OL_HICCUP || state_q == ST_THERMAL_HICCUP);
        irq_events[IRQ_SINK_LIMIT_BIT] = switching && flags.sink_limit && !sink_block_q;
        irq_events[IRQ_OVERVOLTAGE_BIT] = flags.output_overvoltage_guard && !ovp_block_q;
    end

    // Set wins over a clear written in the same cycle
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            irq_status_q <= '0;
        end
        else
        begin
            irq_status_q <= (irq_status_q & ~((apb_write && paddr == IRQ_CLEAR_OFFSET)
                ? pwdata[IRQ_WIDTH-1:0] : '0)) | irq_events;
        end
    end

    assign irq = |(irq_status_q & irq_enable_q);

    // ------------------------------------------------------------------
    // Protection sequencer
    // ------------------------------------------------------------------
    assign switching = (state_q == ST_RUN) && ctrl_q[CTRL_ENABLE_BIT];

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= ST_DISCHARGE;
        end
        else if (flags.over_temp && state_q != ST_THERMAL_WAIT)
        begin
            state_q <= ST_THERMAL_WAIT;
        end
        else
        begin
            case (state_q)
                ST_DISCHARGE:
                    if (flags.soft_start_track_node_low && !flags.over_temp)
                    begin
                        state_q <= ST_RUN;
                    end
                ST_RUN:
                    if (ol_trip)
                    begin
                        state_q <= ST_OL_HICCUP;
                    end
                ST_OL_HICCUP:
                    if (hiccup_done)
                    begin
                        state_q <= ST_DISCHARGE;
                    end
                ST_THERMAL_WAIT:
                    if (flags.cool_below && !flags.over_temp)
                    begin
                        state_q <= ST_THERMAL_HICCUP;
                    end
                ST_THERMAL_HICCUP:
                    if (hiccup_done)
                    begin
                        state_q <= ST_DISCHARGE;
                    end
                default: state_q <= ST_DISCHARGE;
            endcase
        end
    end

    // Overload cycle counter; any clean cycle clears it
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ol_count_q <= '0;
        end
        else if (state_q != ST_RUN || !flags.overload)
        begin
            ol_count_q <= '0;
        end
        else if (tick && ol_count_q < OL_LIMIT)
        begin
            ol_count_q <= ol_count_q + CNT_W'(1);
        end
    end

    // Hiccup counter, shared by the overload and thermal hiccup states
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            hiccup_count_q <= '0;
        end
        else if (state_q != ST_OL_HICCUP && state_q != ST_THERMAL_HICCUP)
        begin
            hiccup_count_q <= '0;
        end
        else if (hiccup_done)
        begin
            hiccup_count_q <= '0;
        end
        else if (tick)
        begin
            hiccup_count_q <= hiccup_count_q + CNT_W'(1);
        end
    end

    // ------------------------------------------------------------------
    // Per-cycle switch control
    // ------------------------------------------------------------------
    // Cycle-start flags: source hold and overvoltage block latch per cycle
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            source_hold_q <= 1'b0;
            ovp_block_q <= 1'b0;
        end
        else if (!switching)
        begin
            source_hold_q <= 1'b0;
            ovp_block_q <= 1'b0;
        end
        else
        begin
            if (tick)
            begin
                source_hold_q <= flags.source_limit && low_on_q;
            end
            if (flags.output_overvoltage_guard)
            begin
                ovp_block_q <= 1'b1;
            end
            else if (tick)
            begin
                ovp_block_q <= 1'b0;
            end
        end
    end

    // Sink limit blocks both switches for the rest of the cycle
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sink_block_q <= 1'b0;
        end
        else if (!switching || tick)
        begin
            sink_block_q <= 1'b0;
        end
        else if (flags.sink_limit && low_on_q)
        begin
            sink_block_q <= 1'b1;
        end
    end

    // Gate state: high at cycle start, low after peak trip
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            high_on_q <= 1'b0;
            low_on_q <= 1'b0;
        end
        else if (!switching)
        begin
            high_on_q <= 1'b0;
            low_on_q <= 1'b0;
        end
        else if (tick)
        begin
            if ((flags.source_limit && low_on_q) || flags.output_overvoltage_guard)
            begin
                high_on_q <= 1'b0;
                low_on_q <= 1'b1;
            end
            else
            begin
                high_on_q <= 1'b1;
                low_on_q <= 1'b0;
            end
        end
        else if (high_on_q && (flags.peak_current_trip || flags.output_overvoltage_guard))
        begin
            high_on_q <= 1'b0;
            low_on_q <= 1'b1;
        end
    end

    // Sink limit and overvoltage gate the drive at once, no cycle of lag
    always_comb
    begin
        gate.high_side_on = switching && high_on_q && !low_on_q
            && !flags.output_overvoltage_guard;
        gate.low_side_on = switching && low_on_q && !high_on_q
            && !sink_block_q && !flags.sink_limit;
        gate.soft_start_discharge = (state_q == ST_DISCHARGE);
    end

endmodule : buck_switch_protection_fsm

// ===== verilog/cycle_tick_gen.sv
`timescale 1ns/1ps
// --------------------------------------------------------------------------
// Switching-cycle tick divider
// --------------------------------------------------------------------------
module cycle_tick_gen
    import buck_pkg::*;
#(
    parameter int DIV_WIDTH = 16
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [DIV_WIDTH-1:0] div_value,
    output logic tick
);

    logic [DIV_WIDTH-1:0] count_q;

    // Divide down; a zero or one divisor gives a tick every clock
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            count_q <= '0;
        end
        else if (count_q + DIV_WIDTH'(1) >= div_value)
        begin
            count_q <= '0;
        end
        else
        begin
            count_q <= count_q + DIV_WIDTH'(1);
        end
    end

    assign tick = (count_q + DIV_WIDTH'(1) >= div_value);

endmodule : cycle_tick_gen

// ===== verilog/flag_sync.sv
`timescale 1ns/1ps
// --------------------------------------------------------------------------
// Two-stage synchroniser for the comparator flags
// --------------------------------------------------------------------------
module flag_sync
    import buck_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta_q <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule : flag_sync
